// file: tpf_teletext_prefix_filter.v
// two programmable teletext prefix filters with their parameter registers
`timescale 1ns/100ps
`default_nettype none
`include "tpf_defines.vh"

// Summary of operation
// - filter one keeps five bytes: compare-select in bits 7..4, match value in 3..0
// - filter two has five identical bytes directly after filter one's
// - nabts examines five prefix bytes, wst examines only the first two
// - only the four data bits of each hamming byte are compared
// - nabts bytes in order: three address bytes, continuity index, packet structure
// - nabts address nibbles compare with bits 7, 5, 3, 1 of each address byte
// - nibbles four and five use bits 7, 5, 3, 1 of index and structure bytes
// - wst nibble one is row0 and magazine 2..0, nibble two is row 4..1
// - in wst nibbles three to five are disregarded
// - select bit one compares value bit with data bit; bit0 pairs first data bit
// - select bit zero makes that data bit a don't-care
// - each filter can pass only if its enable was one at the first prefix byte; enables default zero
// - format bit zero selects nabts, one selects wst
module tpf_teletext_prefix_filter (
  input  wire       sys_clk_in,
  input  wire       rst_b_in,
  input  wire [7:0] reg_addr_in,
  input  wire       reg_wr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_rd_in,
  output wire [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  output reg        reg_wr_refused_out,
  input  wire       flt_one_en_in,
  input  wire       flt_two_en_in,
  input  wire       fmt_wst_in,
  input  wire       txn_start_in,
  input  wire       byte_valid_in,
  input  wire [7:0] byte_in,
  output reg        flt_one_pass_out,
  output reg        flt_two_pass_out,
  output reg        result_valid_out,
  output reg        busy_out
);

  // sequencer states
  localparam ST_IDLE    = 2'b00;
  localparam ST_COLLECT = 2'b01;
  localparam ST_SKIP    = 2'b10;

  // host side decode
  wire                  reg_hit;
  wire [7:0]            reg_offset;
  wire [`TPF_IDX_W-1:0] reg_idx;
  wire                  any_en;
  wire                  wr_accept;

  // sequencer registers
  reg  [1:0]            state_ff;
  reg  [1:0]            nxt_state;
  reg  [`TPF_IDX_W-1:0] idx_ff;
  reg  [`TPF_IDX_W-1:0] nxt_idx;
  reg  [`TPF_IDX_W-1:0] last_ff;
  reg  [`TPF_IDX_W-1:0] nxt_last;
  reg  [1:0]            en_ff;
  reg  [1:0]            nxt_en;
  reg                   take;
  reg                   take_last;
  reg  [`TPF_IDX_W-1:0] take_idx;

  // compare stage registers
  reg  [7:0]            byte_ff;
  reg                   cmp_vld_ff;
  reg                   cmp_first_ff;
  reg                   cmp_last_ff;
  reg  [1:0]            match_ff;
  reg  [1:0]            nxt_match;

  // parameter bytes fetched for the byte under compare
  wire [7:0]            prm_one;
  wire [7:0]            prm_two;
  wire [15:0]           prm_flat;
  wire [3:0]            data_nib;
  wire [1:0]            mismatch;
  wire [`TPF_IDX_W-1:0] rd_one_idx;
  wire [`TPF_IDX_W-1:0] rd_two_idx;

  // host address falls in the ten parameter bytes
  assign reg_hit    = (reg_addr_in >= `TPF_ADDR_F1_B1) &&
                      (reg_addr_in <= `TPF_ADDR_F2_B5);
  assign reg_offset = reg_addr_in - `TPF_ADDR_F1_B1;
  assign reg_idx    = reg_offset[`TPF_IDX_W-1:0]; // filter two follows filter one

  // writes only land while both filter enables are low
  assign any_en     = flt_one_en_in | flt_two_en_in;
  assign wr_accept  = reg_wr_in & reg_hit & ~any_en;

  // read answer and refused-write pulse, one cycle after the strobe
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      reg_rvalid_out     <= 1'b0;
      reg_wr_refused_out <= 1'b0;
    end else begin
      reg_rvalid_out     <= reg_rd_in & reg_hit;
      reg_wr_refused_out <= reg_wr_in & reg_hit & any_en;
    end
  end

  // parameter store, cleared by reset; five bytes per filter
  tpf_param_mem #(
    .WIDTH (8),
    .DEPTH (`TPF_NUM_ENTRIES),
    .AW    (`TPF_IDX_W)
  ) u_param_mem (
    .sys_clk_in    (sys_clk_in),
    .rst_b_in      (rst_b_in),
    .wr_en_in      (wr_accept),
    .wr_addr_in    (reg_idx),
    .wr_data_in    (reg_wdata_in),
    .rd_a_addr_in  (reg_idx),
    .rd_a_data_out (reg_rdata_out),
    .rd_b_addr_in  (rd_one_idx),
    .rd_b_data_out (prm_one),
    .rd_c_addr_in  (rd_two_idx),
    .rd_c_data_out (prm_two)
  );

  // byte k of the prefix uses entry k of each filter
  assign rd_one_idx = take_idx;
  assign rd_two_idx = take_idx + `TPF_F2_BASE;

  // sequencer: decides which incoming bytes belong to the prefix
  always @* begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_last  = last_ff;
    nxt_en    = en_ff;
    take      = 1'b0;
    take_last = 1'b0;
    take_idx  = idx_ff;
    if (txn_start_in && byte_valid_in) begin
      // first byte of a new transaction restarts the count
      take      = 1'b1;
      take_idx  = `TPF_IDX_RESET;
      nxt_en    = {flt_two_en_in, flt_one_en_in};
      // prefix length follows the format select
      if (fmt_wst_in == `TPF_FMT_WST) begin
        nxt_last = `TPF_WST_LAST;
      end else begin
        nxt_last = `TPF_NABTS_LAST;
      end
      take_last = (nxt_last == `TPF_IDX_RESET);
      nxt_idx   = `TPF_IDX_RESET + 4'h1;
      nxt_state = ST_COLLECT;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_state = ST_IDLE;
        end
        ST_COLLECT: begin
          if (byte_valid_in) begin
            take      = 1'b1;
            take_last = (idx_ff == last_ff);
            nxt_idx   = idx_ff + 4'h1;
            if (idx_ff == last_ff) begin
              nxt_state = ST_SKIP;
            end
          end
        end
        ST_SKIP: begin
          // payload after the prefix is not examined
          nxt_state = ST_SKIP;
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
    if (take && take_last) begin
      nxt_state = ST_SKIP;
    end
  end

  // sequencer registers
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
      idx_ff   <= `TPF_IDX_RESET;
      last_ff  <= `TPF_NABTS_LAST;
      en_ff    <= 2'b00; // both filters off after reset
      busy_out <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      last_ff  <= nxt_last;
      en_ff    <= nxt_en;
      busy_out <= (nxt_state == ST_COLLECT);
    end
  end

  // hold the byte while its parameter bytes are fetched
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      byte_ff      <= `TPF_REG_RESET;
      cmp_vld_ff   <= 1'b0;
      cmp_first_ff <= 1'b0;
      cmp_last_ff  <= 1'b0;
    end else begin
      cmp_vld_ff   <= take;
      cmp_first_ff <= take & txn_start_in;
      cmp_last_ff  <= take & take_last;
      if (take) begin
        byte_ff <= byte_in;
      end
    end
  end

  // data bits only, protection bits dropped; first data bit is lsb
  assign data_nib = {byte_ff[`TPF_D4_POS], byte_ff[`TPF_D3_POS],
                     byte_ff[`TPF_D2_POS], byte_ff[`TPF_D1_POS]};

  assign prm_flat = {prm_two, prm_one};

  // per filter masked compare of the current nibble
  genvar gf;
  generate
    for (gf = 0; gf < 2; gf = gf + 1) begin : g_flt
      wire [3:0] sel_nib;
      wire [3:0] val_nib;
      assign sel_nib = prm_flat[gf*8+`TPF_SEL_HI -: 4];
      assign val_nib = prm_flat[gf*8+`TPF_VAL_HI -: 4];
      // clear select bits are don't-care, set ones must match
      assign mismatch[gf] = |(sel_nib & (data_nib ^ val_nib));
    end
  endgenerate

  // running match per filter, restarted by the first byte
  always @* begin
    nxt_match = match_ff;
    if (cmp_vld_ff) begin
      if (cmp_first_ff) begin
        nxt_match = ~mismatch;
      end else begin
        nxt_match = match_ff & ~mismatch;
      end
    end
  end

  // compare stage and verdict on the last prefix byte
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      match_ff         <= 2'b00;
      flt_one_pass_out <= 1'b0;
      flt_two_pass_out <= 1'b0;
      result_valid_out <= 1'b0;
    end else begin
      match_ff         <= nxt_match;
      result_valid_out <= cmp_vld_ff & cmp_last_ff;
      if (cmp_vld_ff && cmp_last_ff) begin
        // a disabled filter never passes anything
        flt_one_pass_out <= en_ff[0] & nxt_match[0];
        flt_two_pass_out <= en_ff[1] & nxt_match[1];
      end else if (txn_start_in) begin
        flt_one_pass_out <= 1'b0;
        flt_two_pass_out <= 1'b0;
      end
    end
  end

endmodule // tpf_teletext_prefix_filter

`default_nettype wire

// file: tpf_defines.vh
// constants shared by the teletext prefix filter files
`ifndef TPF_DEFINES_VH
`define TPF_DEFINES_VH

// register port sub-addresses of the filter parameter bytes
`define TPF_ADDR_F1_B1 8'h90
`define TPF_ADDR_F1_B2 8'h91
`define TPF_ADDR_F1_B3 8'h92
`define TPF_ADDR_F1_B4 8'h93
`define TPF_ADDR_F1_B5 8'h94
`define TPF_ADDR_F2_B1 8'h95
`define TPF_ADDR_F2_B2 8'h96
`define TPF_ADDR_F2_B3 8'h97
`define TPF_ADDR_F2_B4 8'h98
`define TPF_ADDR_F2_B5 8'h99

// parameter store geometry
`define TPF_NUM_ENTRIES 10
`define TPF_IDX_W 4
`define TPF_F2_BASE 4'h5

// field positions inside one parameter byte
`define TPF_SEL_HI 7
`define TPF_SEL_LO 4
`define TPF_VAL_HI 3
`define TPF_VAL_LO 0

// data bit positions inside one hamming protected byte
`define TPF_D1_POS 1
`define TPF_D2_POS 3
`define TPF_D3_POS 5
`define TPF_D4_POS 7

// index of the last prefix byte per teletext format
`define TPF_NABTS_LAST 4'h4
`define TPF_WST_LAST 4'h1

// format select encoding
`define TPF_FMT_NABTS 1'b0
`define TPF_FMT_WST 1'b1

// reset values
`define TPF_REG_RESET 8'h00
`define TPF_IDX_RESET 4'h0

`endif

// file: tpf_param_mem.v
// parameter byte store with one write port and three registered read ports
`timescale 1ns/100ps
`default_nettype none
`include "tpf_defines.vh"

module tpf_param_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 10,
  parameter AW    = 4
) (
  input  wire             sys_clk_in,
  input  wire             rst_b_in,
  input  wire             wr_en_in,
  input  wire [AW-1:0]    wr_addr_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire [AW-1:0]    rd_a_addr_in,
  output reg  [WIDTH-1:0] rd_a_data_out,
  input  wire [AW-1:0]    rd_b_addr_in,
  output reg  [WIDTH-1:0] rd_b_data_out,
  input  wire [AW-1:0]    rd_c_addr_in,
  output reg  [WIDTH-1:0] rd_c_data_out
);

  wire [DEPTH*WIDTH-1:0] flat_mem;
  wire [31:0]            wr_addr_wide;
  wire [31:0]            rd_a_wide;
  wire [31:0]            rd_b_wide;
  wire [31:0]            rd_c_wide;

  // addresses widened so they meet integer indices at equal width
  assign wr_addr_wide = {{(32-AW){1'b0}}, wr_addr_in};
  assign rd_a_wide    = {{(32-AW){1'b0}}, rd_a_addr_in};
  assign rd_b_wide    = {{(32-AW){1'b0}}, rd_b_addr_in};
  assign rd_c_wide    = {{(32-AW){1'b0}}, rd_c_addr_in};

  // one storage cell per entry, cleared by reset
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_cell
      reg [WIDTH-1:0] cell_ff;
      always @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
          cell_ff <= `TPF_REG_RESET;
        end else if (wr_en_in && (wr_addr_wide == gi)) begin
          cell_ff <= wr_data_in;
        end
      end
      assign flat_mem[gi*WIDTH +: WIDTH] = cell_ff;
    end
  endgenerate

  // registered reads, out of range reads give zero
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rd_a_data_out <= `TPF_REG_RESET;
      rd_b_data_out <= `TPF_REG_RESET;
      rd_c_data_out <= `TPF_REG_RESET;
    end else begin
      rd_a_data_out <= (rd_a_wide < DEPTH) ? flat_mem[rd_a_addr_in*WIDTH +: WIDTH]
                                           : `TPF_REG_RESET;
      rd_b_data_out <= (rd_b_wide < DEPTH) ? flat_mem[rd_b_addr_in*WIDTH +: WIDTH]
                                           : `TPF_REG_RESET;
      rd_c_data_out <= (rd_c_wide < DEPTH) ? flat_mem[rd_c_addr_in*WIDTH +: WIDTH]
                                           : `TPF_REG_RESET;
    end
  end

endmodule // tpf_param_mem

`default_nettype wire

// file: tpf_monitor.sv
// port checker for the teletext prefix filter
`timescale 1ns/100ps
`default_nettype none
module tpf_monitor (
  input wire logic       sys_clk_in,
  input wire logic       rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic       reg_rvalid_out,
  input wire logic       reg_wr_refused_out,
  input wire logic       flt_one_en_in,
  input wire logic       flt_two_en_in,
  input wire logic       fmt_wst_in,
  input wire logic       txn_start_in,
  input wire logic       byte_valid_in,
  input wire logic       flt_one_pass_out,
  input wire logic       flt_two_pass_out,
  input wire logic       result_valid_out,
  input wire logic       busy_out
);
  // address falls in the parameter window
  wire reg_hit = (reg_addr_in >= 8'h90) && (reg_addr_in <= 8'h99);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // two byte and five byte prefixes
  sequence s_wst;
    txn_start_in && byte_valid_in && fmt_wst_in ##1 byte_valid_in && !txn_start_in;
  endsequence
  sequence s_nabts;
    txn_start_in && byte_valid_in && !fmt_wst_in ##1 (byte_valid_in && !txn_start_in)[*4];
  endsequence
  property p_wst; s_wst |-> ##2 result_valid_out; endproperty
  property p_nabts; s_nabts |-> ##2 result_valid_out; endproperty
  property p_rd; reg_rvalid_out |-> $past(reg_rd_in) && $past(reg_hit); endproperty
  property p_unm; reg_rd_in && !reg_hit |=> !reg_rvalid_out; endproperty
  property p_ref;
    reg_wr_in && reg_hit && (flt_one_en_in || flt_two_en_in) |=> reg_wr_refused_out;
  endproperty
  property p_acc;
    reg_wr_in && reg_hit && !flt_one_en_in && !flt_two_en_in |=> !reg_wr_refused_out;
  endproperty
  property p_clr;
    txn_start_in && byte_valid_in |-> ##[1:2] !flt_one_pass_out && !flt_two_pass_out;
  endproperty
  property p_busy; txn_start_in && byte_valid_in |=> busy_out; endproperty
  property p_dis; result_valid_out && !flt_one_en_in |-> !flt_one_pass_out; endproperty
  a_wst: assert property (p_wst) else $error("wst verdict late");
  a_nabts: assert property (p_nabts) else $error("nabts verdict late");
  a_rd: assert property (p_rd) else $error("read answer without request");
  a_unm: assert property (p_unm) else $error("unmapped read answered");
  a_ref: assert property (p_ref) else $error("write not refused");
  a_acc: assert property (p_acc) else $error("write wrongly refused");
  a_clr: assert property (p_clr) else $error("verdict not cleared");
  a_busy: assert property (p_busy) else $error("busy missing");
  a_dis: assert property (p_dis) else $error("disabled filter passed");
endmodule // tpf_monitor
bind tpf_teletext_prefix_filter tpf_monitor u_mon (.sys_clk_in, .rst_b_in, .reg_addr_in,
  .reg_wr_in, .reg_rd_in, .reg_rvalid_out, .reg_wr_refused_out, .flt_one_en_in,
  .flt_two_en_in, .fmt_wst_in, .txn_start_in, .byte_valid_in, .flt_one_pass_out,
  .flt_two_pass_out, .result_valid_out, .busy_out);
`default_nettype wire

// file: tpf_host.sv
// host model for the parameter register port
`timescale 1ns/100ps
`default_nettype none
module tpf_host (
  input  wire logic       clk_in,
  output var  logic [7:0] addr_out,
  output var  logic [7:0] wdata_out,
  output var  logic       wr_out,
  output var  logic       rd_out
);
  // idle port
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one write pulse, issued whatever the enables are
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  // one read pulse
  task rd_reg(input logic [7:0] a);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
  endtask
  // consecutive reads from the first byte on
  task rd_run(input logic [7:0] a, input int n);
    for (int j = 0; j < n; j++)
      rd_reg(a + 8'(j));
  endtask
endmodule // tpf_host
`default_nettype wire

// file: tpf_teletext_prefix_filter_tb.sv
// self-checking bench for the teletext prefix filter
`timescale 1ns/100ps
`default_nettype none
module tpf_teletext_prefix_filter_tb;
  logic       sys_clk, rst_b, en1, en2, wst, start, bv, wr, rd;
  logic       rvalid, refused, p1, p2, rv, busy;
  logic [7:0] addr, wdata, byte_d, rdata, v;
  logic [7:0] regs [10];
  logic [7:0] bt [5];
  logic [7:0] eq [$];
  logic [1:0] vq [$];
  int         bad_count, cmp_count, cyc, seed, i, k;
  int         ref_seen, busy_run;
  tpf_host u_host (.clk_in(sys_clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd));
  tpf_teletext_prefix_filter DUT (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .reg_wr_refused_out(refused), .flt_one_en_in(en1),
    .flt_two_en_in(en2), .fmt_wst_in(wst), .txn_start_in(start), .byte_valid_in(bv),
    .byte_in(byte_d), .flt_one_pass_out(p1), .flt_two_pass_out(p2),
    .result_valid_out(rv), .busy_out(busy));
  // free running clock
  always #5 sys_clk = ~sys_clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // expected verdict pair from the shadow store
  function automatic logic [1:0] verdict();
    logic [1:0] r;
    logic [3:0] nib;
    r = {en1, en2};
    for (int f = 0; f < 2; f++)
      for (int b = 0; b < (wst ? 2 : 5); b++) begin
        nib = {bt[b][7], bt[b][5], bt[b][3], bt[b][1]};
        if ((regs[f*5+b][7:4] & (nib ^ regs[f*5+b][3:0])) != 4'h0) r[1-f] = 1'b0;
      end
    return r;
  endfunction
  // back to back prefix bytes
  task send(input int n);
    for (int b = 0; b < n; b++) begin
      @(negedge sys_clk);
      start = (b == 0);
      bv = 1'b1;
      byte_d = bt[b];
    end
    @(negedge sys_clk);
    start = 1'b0;
    bv = 1'b0;
    byte_d = ~byte_d;
  endtask
  // results against the oldest notes
  always @(posedge sys_clk) begin
    if (refused === 1'b1) ref_seen++;
    // busy cycles of the current prefix, restarted by its first byte
    if (start === 1'b1 && bv === 1'b1) busy_run = 0;
    else if (busy === 1'b1) busy_run++;
    if (rvalid === 1'b1) begin
      if (eq.size() == 0) begin
        bad_count++;
        $display("mismatch at %0t: read answer without note", $time);
      end
      else chk(rdata, eq.pop_front()); // read data and reset value
    end
    if (rv === 1'b1) begin
      if (vq.size() == 0) begin
        bad_count++;
        $display("mismatch at %0t: verdict without note", $time);
      end
      else chk({6'h00, p1, p2}, {6'h00, vq.pop_front()}); // verdict
      chk(8'(busy_run), wst ? 8'h01 : 8'h04); // busy covers the prefix bytes after the first
    end
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    seed = 47;
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {en1, en2, wst, start, bv} = 5'h00;
    byte_d = 8'h00;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    for (k = 0; k < 10; k++) regs[k] = 8'h00;
    for (k = 0; k < 10; k++) eq.push_back(8'h00);
    u_host.rd_run(8'h90, 10);
    u_host.rd_reg(8'h8f);
    for (i = 0; i < 40; i++) begin
      for (k = 0; k < 10; k++) begin
        v = $random(seed);
        v[7:4] = (i % 5 == 0) ? 4'h0 : v[7:4] & 4'($random(seed));
        regs[k] = v;
        eq.push_back(v);
        u_host.wr_reg(8'h90 + 8'(k), v);
      end
      u_host.rd_run(8'h90, 10);
      for (k = 0; k < 5; k++) begin
        bt[k] = $random(seed);
        if (i % 4 == 1) {bt[k][7], bt[k][5], bt[k][3], bt[k][1]} = regs[k][3:0];
      end
      @(negedge sys_clk);
      {en1, en2, wst} = 3'($random(seed));
      if (i % 7 == 3) send(1);
      vq.push_back(verdict());
      send(5);
      repeat (4) @(negedge sys_clk);
      {en1, en2} = 2'h0;
    end
    @(negedge sys_clk);
    en1 = 1'b1;
    u_host.wr_reg(8'h90, ~regs[0]);
    en1 = 1'b0;
    eq.push_back(regs[0]);
    u_host.rd_run(8'h90, 1);
    repeat (4) @(negedge sys_clk);
    chk(8'(ref_seen), 8'h01); // one refused write pulse
    tally_and_finish;
  end
endmodule // tpf_teletext_prefix_filter_tb
`default_nettype wire
